// file: rtl/devctl_pkg.sv
// Summary of operation
// RL1: control bits 0 to 3 are read-write enables for correctable, non-fatal, fatal and unsupported request reporting, reset zero.
// RL2: control bit 4, relaxed ordering enable, reads zero and ignores writes.
// RL3: control bits 7:5 select the payload limit, codes 0 to 4 giving 128 to 2048 bytes, reset zero.
// RL4: reserved payload codes 5, 6 and 7 act exactly like the 128 byte limit.
// RL5: control bit 8, wide tag enable, is read-write, reset zero, and has no effect in normal operation.
// RL6: with sequential tag debug set, tags run 0 to 31 when the wide tag enable is clear and 0 to 255 when it is set.
// RL7: control bit 9, phantom function enable, is hardwired zero.
// RL8: control bit 10, auxiliary power management enable, reads zero.
// RL9: control bit 11, no-snoop enable, reads zero.
// RL10: control bits 14:12, maximum read request size, read zero.
// RL11: status bits 0 to 2 set on correctable, non-fatal and fatal errors regardless of enables and clear on a written one.
// RL12: status bit 3 sets on an unsupported request regardless of its enable, resets zero and clears on a written one.
// RL13: status bit 4, auxiliary power seen, reads zero.
// RL14: status bit 5, transactions pending, reads zero.
// RL15: reserved bits, control bit 15 and status bits 15:6, read zero and ignore writes.
package devctl_pkg;
  localparam logic [11:0] DEV_CTL_IDX     = 12'h048;
  localparam logic [11:0] DEV_STS_IDX     = 12'h04A;
  localparam logic [11:0] DEV_CTL_ADDR    = 12'(DEV_CTL_IDX * 4);
  localparam logic [11:0] DEV_STS_ADDR    = 12'(DEV_STS_IDX * 4);
  localparam logic [11:0] IRQ_MASK_ADDR   = 12'h200;
  localparam logic [11:0] TL_CTL_ADDR     = 12'h204;
  localparam int          EN_LSB          = 0;
  localparam int          MPS_LSB         = 5;
  localparam int          WIDE_TAG_BIT    = 8;
  localparam int          SEQ_TAG_BIT     = 0;
  localparam logic [3:0]  EN_RST          = 4'h0;
  localparam logic [2:0]  MPS_RST         = 3'h0;
  localparam logic [3:0]  STS_RST         = 4'h0;
  localparam logic [3:0]  MASK_RST        = 4'h0;
  localparam logic [7:0]  NARROW_TAG_MAX  = 8'h1F;
  localparam logic [7:0]  WIDE_TAG_MAX    = 8'hFF;
  localparam logic [11:0] PAYLOAD_128     = 12'h080;
  localparam logic [11:0] PAYLOAD_256     = 12'h100;
  localparam logic [11:0] PAYLOAD_512     = 12'h200;
  localparam logic [11:0] PAYLOAD_1024    = 12'h400;
  localparam logic [11:0] PAYLOAD_2048    = 12'h800;
endpackage : devctl_pkg

// file: rtl/device_ctl_status.sv
`timescale 1ns/1ps
`default_nettype none
module device_ctl_status
  import devctl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        correctable_err,
  input  wire logic        nonfatal_err,
  input  wire logic        fatal_err,
  input  wire logic        unsupported_req,
  input  wire logic        tag_advance,
  output logic             correctable_report_en,
  output logic             nonfatal_report_en,
  output logic             fatal_report_en,
  output logic             unsupported_req_report_en,
  output logic             wide_tag_en,
  output logic [11:0]      max_payload_bytes,
  output logic [7:0]       debug_tag,
  output logic             irq
);
  logic [3:0]  en_q, en_d;
  logic [2:0]  mps_q, mps_d;
  logic        wide_q, wide_d;
  logic [3:0]  sts_q, sts_d;
  logic [3:0]  mask_q, mask_d;
  logic        seq_q, seq_d;
  logic [7:0]  tag_q, tag_d;
  logic [11:0] payload_q, payload_d;
  logic        pready_q, prdy_d;
  logic [31:0] prdata_q, rdata_d;
  logic        pslverr_q, err_d;
  logic        irq_q, irq_d;

  wire         access    = psel & penable;
  wire         fire      = access & pready_q;
  wire         wr_fire   = fire & pwrite;
  wire         hit_ctl   = paddr == DEV_CTL_ADDR;
  wire         hit_sts   = paddr == DEV_STS_ADDR;
  wire         hit_mask  = paddr == IRQ_MASK_ADDR;
  wire         hit_tl    = paddr == TL_CTL_ADDR;
  wire         mapped    = hit_ctl | hit_sts | hit_mask | hit_tl;
  wire         wr_lo     = wr_fire & pstrb[0];
  wire         wr_hi     = wr_fire & pstrb[1];
  wire [3:0]   events    = {unsupported_req, fatal_err, nonfatal_err, correctable_err};
  // read-only and reserved control bits are never stored, so they read zero
  wire [15:0]  ctl_view  = {7'h00, wide_q, mps_q, 1'b0, en_q}; // RL2 RL7 RL8 RL9 RL10 RL15
  wire [15:0]  sts_view  = {12'h000, sts_q}; // RL13 RL14 RL15
  wire [3:0]   sts_clr   = (wr_lo & hit_sts) ? pwdata[3:0] : 4'h0;
  wire [7:0]   tag_max   = wide_q ? WIDE_TAG_MAX : NARROW_TAG_MAX; // RL6

  assign en_d      = (wr_lo & hit_ctl) ? pwdata[EN_LSB +: 4] : en_q; // RL1
  assign mps_d     = (wr_lo & hit_ctl) ? pwdata[MPS_LSB +: 3] : mps_q; // RL3
  assign wide_d    = (wr_hi & hit_ctl) ? pwdata[WIDE_TAG_BIT] : wide_q; // RL5
  // set beats clear so an error in the clearing cycle survives
  assign sts_d     = (sts_q & ~sts_clr) | events; // RL11 RL12
  assign mask_d    = (wr_lo & hit_mask) ? pwdata[3:0] : mask_q;
  assign seq_d     = (wr_lo & hit_tl) ? pwdata[SEQ_TAG_BIT] : seq_q;
  assign tag_d     = !seq_q ? 8'h00 : !tag_advance ? tag_q
                   : (tag_q >= tag_max) ? 8'h00 : tag_q + 8'h01; // RL6
  assign irq_d     = |(sts_d & mask_d);
  assign prdy_d    = access & ~pready_q;
  assign err_d     = ~mapped;
  assign rdata_d   = hit_ctl  ? {16'h0000, ctl_view}
                   : hit_sts  ? {16'h0000, sts_view}
                   : hit_mask ? {28'h0000000, mask_q}
                   : hit_tl   ? {31'h00000000, seq_q} : 32'h00000000;

  always_comb begin
    unique case (mps_q) // RL3 RL4
      3'h0:    payload_d = PAYLOAD_128;
      3'h1:    payload_d = PAYLOAD_256;
      3'h2:    payload_d = PAYLOAD_512;
      3'h3:    payload_d = PAYLOAD_1024;
      3'h4:    payload_d = PAYLOAD_2048;
      default: payload_d = PAYLOAD_128; // reserved codes fall back
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= EN_RST;
    end else begin
      en_q <= en_d; // RL1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mps_q <= MPS_RST;
    end else begin
      mps_q <= mps_d; // RL3
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_q <= 1'b0;
    end else begin
      wide_q <= wide_d; // RL5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q <= STS_RST;
    end else begin
      sts_q <= sts_d; // RL11 RL12
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= MASK_RST;
    end else begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_q <= 1'b0;
    end else begin
      seq_q <= seq_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_q <= 8'h00;
    end else begin
      tag_q <= tag_d; // RL6
    end
  end

  // one wait state keeps prdata straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= prdy_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdy_d ? rdata_d : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else begin
      pslverr_q <= prdy_d & err_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_q <= PAYLOAD_128;
    end else begin
      payload_q <= payload_d; // RL3 RL4
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign pready                    = pready_q;
  assign prdata                    = prdata_q;
  assign pslverr                   = pslverr_q;
  assign correctable_report_en     = en_q[0];
  assign nonfatal_report_en        = en_q[1];
  assign fatal_report_en           = en_q[2];
  assign unsupported_req_report_en = en_q[3];
  assign wide_tag_en               = wide_q;
  assign max_payload_bytes         = payload_q;
  assign debug_tag                 = tag_q;
  assign irq                       = irq_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_ctl_write;
    wr_fire && hit_ctl && pstrb[0];
  endsequence

  sequence s_sts_write;
    wr_lo && hit_sts;
  endsequence

  sequence s_mask_write;
    wr_lo && hit_mask;
  endsequence

  sequence s_tl_write;
    wr_lo && hit_tl;
  endsequence

  sequence s_wait_state;
    access && !pready_q;
  endsequence

  sequence s_tag_step;
    seq_q && tag_advance;
  endsequence

  AST_EN_WRITE: assert property (s_ctl_write |=> en_q == $past(pwdata[3:0])) // RL1
    else $error("report enables did not take written value");
  AST_CTL_RO_ZERO: assert property (fire && hit_ctl && !pwrite |-> // RL2 RL7 RL8 RL9 RL10
                                    prdata[4] == 1'b0 && prdata[15:9] == 7'h00)
    else $error("read-only control bits not zero");
  AST_MPS_VALID: assert property ((s_ctl_write and pwdata[7:5] == 3'h4) |-> ##2 // RL3
                                  max_payload_bytes == PAYLOAD_2048)
    else $error("payload code 4 not 2048 bytes");
  AST_MPS_RESERVED: assert property (mps_q >= 3'h5 |=> max_payload_bytes == PAYLOAD_128) // RL4
    else $error("reserved payload code not 128 bytes");
  AST_WIDE_WRITE: assert property (wr_fire && hit_ctl && pstrb[1] |=>
                                   wide_tag_en == $past(pwdata[8])) // RL5
    else $error("wide tag enable not written");
  AST_TAG_WRAP: assert property (seq_q && !wide_q && tag_advance && tag_q == 8'h1F
                                 && !(wr_fire && hit_tl) |=> debug_tag == 8'h00) // RL6
    else $error("narrow tag did not wrap at 31");
  AST_TAG_RANGE: assert property (!wide_q && debug_tag <= 8'h1F |=> debug_tag <= 8'h1F) // RL6
    else $error("narrow tag out of range");
  AST_STS_SET: assert property (correctable_err |=> sts_q[0]) // RL11
    else $error("correctable error not logged");
  AST_UR_SET_WINS: assert property (unsupported_req && sts_clr[3] |=> sts_q[3]) // RL12
    else $error("unsupported request lost to clear");
  AST_STS_CLEAR: assert property (sts_clr[1] && !nonfatal_err |=> !sts_q[1]) // RL11
    else $error("non-fatal flag did not clear");
  AST_STS_RSVD: assert property (fire && hit_sts |-> ##0 prdata[31:4] == 28'h0000000) // RL13 RL14 RL15
    else $error("reserved status bits not zero");
  AST_IRQ: assert property (##1 irq == |($past(sts_d) & $past(mask_d)))
    else $error("interrupt does not follow masked status");

  // bus handshake
  AST_PREADY_WAIT: assert property (s_wait_state |=> pready)
    else $error("no ready after one wait state");
  AST_PREADY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_PRDATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
    else $error("read data not zero outside ready");
  AST_SLVERR_READY: assert property (pslverr |-> pready)
    else $error("error flagged without ready");
  AST_SLVERR_UNMAPPED: assert property (fire && !mapped |-> pslverr)
    else $error("unmapped access not flagged");
  AST_MAPPED_OK: assert property (fire && mapped |-> !pslverr)
    else $error("mapped access flagged as error");

  // control register
  AST_EN_HOLD: assert property (!(wr_lo && hit_ctl) |=> en_q == $past(en_q)) // RL1
    else $error("report enables changed without write");
  AST_MPS_HOLD: assert property (!(wr_lo && hit_ctl) |=> mps_q == $past(mps_q)) // RL3
    else $error("payload code changed without write");
  AST_WIDE_HOLD: assert property (!(wr_hi && hit_ctl) |=> wide_q == $past(wide_q)) // RL5
    else $error("wide tag enable changed without write");
  AST_MPS_WRITE: assert property (s_ctl_write |=> mps_q == $past(pwdata[7:5])) // RL3
    else $error("payload code did not take written value");
  AST_PAYLOAD_CODE0: assert property (mps_q == 3'h0 |=> max_payload_bytes == PAYLOAD_128) // RL3
    else $error("payload code 0 not 128 bytes");
  AST_PAYLOAD_CODE1: assert property (mps_q == 3'h1 |=> max_payload_bytes == PAYLOAD_256) // RL3
    else $error("payload code 1 not 256 bytes");
  AST_PAYLOAD_CODE2: assert property (mps_q == 3'h2 |=> max_payload_bytes == PAYLOAD_512) // RL3
    else $error("payload code 2 not 512 bytes");
  AST_PAYLOAD_CODE3: assert property (mps_q == 3'h3 |=> max_payload_bytes == PAYLOAD_1024) // RL3
    else $error("payload code 3 not 1024 bytes");
  AST_CTL_READ: assert property (fire && hit_ctl && !pwrite |-> // RL15
                                 prdata[31:16] == 16'h0000 && prdata[15:0] == ctl_view)
    else $error("control read does not match stored bits");

  // status register
  AST_STS_READ: assert property (fire && hit_sts && !pwrite |-> // RL11 RL12
                                 prdata[3:0] == $past(sts_q))
    else $error("status read does not match flags");
  AST_NONFATAL_SET: assert property (nonfatal_err |=> sts_q[1]) // RL11
    else $error("non-fatal error not logged");
  AST_FATAL_SET: assert property (fatal_err |=> sts_q[2]) // RL11
    else $error("fatal error not logged");
  AST_UR_SET: assert property (unsupported_req |=> sts_q[3]) // RL12
    else $error("unsupported request not logged");
  AST_FATAL_CLEAR: assert property ((s_sts_write and pwdata[2] && !fatal_err) |=> !sts_q[2]) // RL11
    else $error("fatal flag did not clear");
  AST_STS_HOLD: assert property (sts_clr == 4'h0 |=> (sts_q & $past(sts_q)) == $past(sts_q)) // RL11
    else $error("status flag dropped without clear");
  AST_STS_NO_SPURIOUS: assert property (events == 4'h0 |=> (sts_q & ~$past(sts_q)) == 4'h0) // RL12
    else $error("status flag set without event");

  // own registers and debug tag
  AST_MASK_WRITE: assert property (s_mask_write |=> mask_q == $past(pwdata[3:0]))
    else $error("mask did not take written value");
  AST_SEQ_WRITE: assert property (s_tl_write |=> seq_q == $past(pwdata[SEQ_TAG_BIT])) // RL6
    else $error("sequential tag control not written");
  AST_TAG_IDLE: assert property (!seq_q |=> debug_tag == 8'h00) // RL6
    else $error("tag not zero with sequential tags off");
  AST_TAG_STEP: assert property ((s_tag_step and debug_tag < tag_max) |=> // RL6
                                 debug_tag == $past(debug_tag) + 8'h01)
    else $error("tag did not advance by one");
  AST_TAG_WIDE_WRAP: assert property ((s_tag_step and (wide_q && debug_tag == 8'hFF)) |=> // RL6
                                      debug_tag == 8'h00)
    else $error("wide tag did not wrap at 255");
  AST_TAG_HOLD: assert property (seq_q && !tag_advance |=> debug_tag == $past(debug_tag)) // RL6
    else $error("tag moved without advance");
endmodule : device_ctl_status
`default_nettype wire

// file: tb/pcie_device_ctl_status_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pcie_device_ctl_status_regs_tb_top;
  import devctl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, tag_advance;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  evt;
  logic        pready, pslverr, irq, ce, ne, fe, ue, wt, e;
  logic [11:0] mpb;
  logic [7:0]  dtag;
  int          n_errors, total_checks;
  logic [11:0] pl [8] = '{PAYLOAD_128, PAYLOAD_256, PAYLOAD_512, PAYLOAD_1024,
                          PAYLOAD_2048, PAYLOAD_128, PAYLOAD_128, PAYLOAD_128};
  device_ctl_status dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .correctable_err(evt[0]), .nonfatal_err(evt[1]),
    .fatal_err(evt[2]), .unsupported_req(evt[3]), .tag_advance(tag_advance),
    .correctable_report_en(ce), .nonfatal_report_en(ne), .fatal_report_en(fe),
    .unsupported_req_report_en(ue), .wide_tag_en(wt), .max_payload_bytes(mpb),
    .debug_tag(dtag), .irq(irq));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic conclude;
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // release is followed by an edge so back-to-back calls never drive psel twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      conclude();
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    #1;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd
  task automatic ev(input logic [3:0] m);
    @(posedge pclk);
    evt <= m;
    @(posedge pclk);
    evt <= 4'h0;
    @(posedge pclk);
    #1;
  endtask : ev
  task automatic adv(input int n);
    @(posedge pclk);
    repeat (n) begin
      tag_advance <= 1'b1;
      @(posedge pclk);
    end
    tag_advance <= 1'b0;
    @(posedge pclk);
    #1;
  endtask : adv
  initial begin
    n_errors = 0; total_checks = 0; presetn = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; evt = 4'h0; tag_advance = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk({ce, ne, fe, ue, wt}, 32'h0);
    chk(mpb, PAYLOAD_128);
    rd(DEV_CTL_ADDR, 32'h0);
    rd(DEV_STS_ADDR, 32'h0);
    ev(4'hF);
    chk(irq, 32'h0);
    rd(DEV_STS_ADDR, 32'hF);
    apb(1'b1, IRQ_MASK_ADDR, 32'hF);
    chk(irq, 32'h1);
    apb(1'b1, DEV_STS_ADDR, 32'h5);
    rd(DEV_STS_ADDR, 32'hA);
    apb(1'b1, IRQ_MASK_ADDR, 32'h1);
    chk(irq, 32'h0);
    apb(1'b1, DEV_STS_ADDR, 32'hFFFF_FFFF);
    rd(DEV_STS_ADDR, 32'h0);
    ev(4'h1);
    chk(irq, 32'h1);
    apb(1'b1, DEV_CTL_ADDR, 32'hFFFF_FFFF);
    rd(DEV_CTL_ADDR, 32'h1EF);
    chk({ce, ne, fe, ue, wt}, 32'h1F);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, DEV_CTL_ADDR, 32'(c) << 5);
      chk(mpb, pl[c]);
    end
    apb(1'b1, TL_CTL_ADDR, 32'h1);
    adv(31);
    chk(dtag, NARROW_TAG_MAX);
    adv(1);
    chk(dtag, 32'h0);
    apb(1'b1, DEV_CTL_ADDR, 32'h100);
    adv(32);
    chk(dtag, 32'h20);
    adv(223);
    chk(dtag, WIDE_TAG_MAX);
    adv(1);
    chk(dtag, 32'h0);
    adv(33);
    apb(1'b1, TL_CTL_ADDR, 32'h0);
    chk(dtag, 32'h0);
    apb(1'b0, 12'h300, 32'h0);
    chk(e, 32'h1);
    chk(r, 32'h0);
    conclude();
  end
endmodule : pcie_device_ctl_status_regs_tb_top
`default_nettype wire
